//--- core/wdtu_pkg.sv
/*
 * wdtu_pkg: register map, field positions, reset values and bus structs
 * for the watchdog time-out unit.
 * assumes: AHB-Lite slave with 32-bit data, one aligned word per register.
 */
package wdtu_pkg;

   localparam logic [11:0] OFF_LOAD = 12'h000;
   localparam logic [11:0] OFF_VALUE = 12'h004;
   localparam logic [11:0] OFF_CTRL = 12'h008;
   localparam logic [11:0] OFF_CLEAR = 12'h00c;
   localparam logic [11:0] OFF_RAW = 12'h010;
   localparam logic [11:0] OFF_MASKED = 12'h014;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
   localparam logic [11:0] OFF_LOCK = 12'hc00;

   localparam int CTRL_TIMEOUT_INTERRUPT_ENABLE_BIT = 0;
   localparam int CTRL_RESET_OUTPUT_ENABLE_BIT = 1;
   localparam int RAW_TIMEOUT_BIT = 0;

   localparam logic [31:0] LOAD_RESET = 32'hffffffff;
   localparam logic [31:0] UNLOCK_KEY = 32'h1acce551;
   localparam logic [31:0] LOCKED_READ = 32'h00000001;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic reset_output_enable;
      logic timeout_interrupt_enable;
   } wdtu_ctrl_s;

   typedef struct packed {
      logic [11:0] addr;
      logic write;
   } wdtu_addr_s;

endpackage

//--- core/wdtu_top.sv
/*
 * wdtu_top: watchdog time-out unit with AHB-Lite register slave, lock,
 * first-expiry interrupt and second-expiry system reset request.
 * assumes: one 100 MHz clock hclk, asynchronous active-low hresetn, a single
 * AHB-Lite master issuing word transfers; the slave is always zero-wait OKAY.
 */
//
// Behaviour
// [RULE1] count down 32 bits, time-out at zero
// [RULE2] interrupt enable also starts the counter
// [RULE3] reload from load value after first time-out
// [RULE4] second expiry while pending, reset enabled: reset
// [RULE5] clear before second expiry: reload, no reset
// [RULE6] load write reloads counter at once
// [RULE7] load write leaves pending interrupt set
// [RULE8] only clear register write clears interrupt
// [RULE9] separate interrupt and reset enables
// [RULE10] enabling interrupt preloads from load value
// [RULE11] non-key lock write locks all registers
// [RULE12] key write unlocks registers
// [RULE13] software: load, reset enable, then interrupt enable
// [RULE14] software enables peripheral clock first
// [RULE15] control writes ignored once interrupt enabled
// [RULE16] zero load raises interrupt immediately
// [RULE17] clear write clears flag and reloads
// [RULE18] masked flag is raw AND interrupt enable
// [RULE19] raw flag sticky until clear or reset
`timescale 1ns/1ps
`default_nettype none

module wdtu_top (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // system side
   output logic wdt_irq,
   output logic sys_reset_req
);

   // address phase capture
   wdtu_pkg::wdtu_addr_s aph_reg;
   logic aph_valid_reg;
   wire addr_take = hsel && hready && (htrans == wdtu_pkg::HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_valid_reg <= 1'b0;
         aph_reg <= '0;
      end else begin
         aph_valid_reg <= addr_take;
         if (addr_take) begin
            aph_reg <= '{addr: haddr[11:0], write: hwrite};
         end
      end
   end

   // state
   logic [31:0] load_reg;
   logic [31:0] count_reg;
   wdtu_pkg::wdtu_ctrl_s ctrl_reg;
   logic raw_reg;
   logic mask_reg;
   logic locked_reg;

   // one decoder for every register write hit, so all offsets compare alike
   function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
      return addr == off;
   endfunction

   wire wr = aph_valid_reg && aph_reg.write;
   wire rd_take = addr_take && !hwrite;
   wire unlocked = !locked_reg;
   wire wr_load = wr && unlocked && hit(aph_reg.addr, wdtu_pkg::OFF_LOAD);
   wire wr_ctrl = wr && unlocked && hit(aph_reg.addr, wdtu_pkg::OFF_CTRL)
      && !ctrl_reg.timeout_interrupt_enable; // [RULE15]
   wire wr_clear = wr && unlocked && hit(aph_reg.addr, wdtu_pkg::OFF_CLEAR); // [RULE8]
   wire wr_mask = wr && unlocked && hit(aph_reg.addr, wdtu_pkg::OFF_IRQ_MASK);
   wire wr_lock = wr && hit(aph_reg.addr, wdtu_pkg::OFF_LOCK);

   wdtu_pkg::wdtu_ctrl_s ctrl_next;
   assign ctrl_next = wr_ctrl ? '{reset_output_enable: hwdata[wdtu_pkg::CTRL_RESET_OUTPUT_ENABLE_BIT],
      timeout_interrupt_enable: hwdata[wdtu_pkg::CTRL_TIMEOUT_INTERRUPT_ENABLE_BIT]} : ctrl_reg; // [RULE9]
   wire timeout_interrupt_enable_rise = ctrl_next.timeout_interrupt_enable && !ctrl_reg.timeout_interrupt_enable;

   // counter runs only with interrupt enabled
   wire running = ctrl_reg.timeout_interrupt_enable; // [RULE2]
   wire expire = running && (count_reg == wdtu_pkg::ZERO_WORD); // [RULE1]
   wire reload = expire || wr_clear || timeout_interrupt_enable_rise; // [RULE3] [RULE5] [RULE10] [RULE17]
   wire zero_load = wr_load && (hwdata == wdtu_pkg::ZERO_WORD); // [RULE16]

   logic [31:0] count_next;
   assign count_next = wr_load ? hwdata : // [RULE6]
      reload ? load_reg :
      running ? count_reg - 32'h00000001 : count_reg;

   wire raw_set = (expire && !raw_reg) || (zero_load && running);
   wire raw_next = raw_set || (raw_reg && !wr_clear); // [RULE7] [RULE19]

   // second expiry with flag still pending; a clear in the same cycle saves the system
   wire reset_fire = expire && raw_reg && !wr_clear && ctrl_reg.reset_output_enable; // [RULE4]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_reg <= wdtu_pkg::LOAD_RESET;
         count_reg <= wdtu_pkg::LOAD_RESET;
         ctrl_reg <= '0;
         raw_reg <= 1'b0;
         mask_reg <= 1'b1;
         locked_reg <= 1'b0;
         sys_reset_req <= 1'b0;
         wdt_irq <= 1'b0;
      end else begin
         if (wr_load) begin
            load_reg <= hwdata;
         end
         count_reg <= count_next;
         ctrl_reg <= ctrl_next;
         raw_reg <= raw_next;
         if (wr_mask) begin
            mask_reg <= hwdata[0];
         end
         if (wr_lock) begin
            locked_reg <= (hwdata != wdtu_pkg::UNLOCK_KEY); // [RULE11] [RULE12]
         end
         if (reset_fire) begin
            sys_reset_req <= 1'b1;
         end
         wdt_irq <= raw_next && ctrl_next.timeout_interrupt_enable && mask_reg;
      end
   end

   // read mux, data registered in address phase for the next data phase
   logic [31:0] rd_word;
   wire [11:0] ra = haddr[11:0];
   wire masked = raw_reg && ctrl_reg.timeout_interrupt_enable; // [RULE18]
   always_comb begin
      case (ra)
         wdtu_pkg::OFF_LOAD: rd_word = load_reg;
         wdtu_pkg::OFF_VALUE: rd_word = count_reg;
         wdtu_pkg::OFF_CTRL: rd_word = {30'h0, ctrl_reg.reset_output_enable, ctrl_reg.timeout_interrupt_enable};
         wdtu_pkg::OFF_RAW: rd_word = {31'h0, raw_reg};
         wdtu_pkg::OFF_MASKED: rd_word = {31'h0, masked};
         wdtu_pkg::OFF_IRQ_MASK: rd_word = {31'h0, mask_reg};
         wdtu_pkg::OFF_LOCK: rd_word = locked_reg ? wdtu_pkg::LOCKED_READ : wdtu_pkg::ZERO_WORD;
         default: rd_word = wdtu_pkg::ZERO_WORD;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (rd_take) begin
            hrdata <= rd_word;
         end
      end
   end

   // checks
   a_reload_on_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE17]
      wr_clear && !wr_load |=> count_reg == load_reg)
      else $error("clear write did not reload counter");
   a_clear_drops_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
      wr_clear |=> !raw_reg)
      else $error("clear write did not drop raw flag");
   a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE19]
      raw_reg && !wr_clear |=> raw_reg)
      else $error("raw flag fell without clear");
   a_load_keeps_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
      wr_load && raw_reg && !wr_clear |=> raw_reg && count_reg == $past(hwdata))
      else $error("load write disturbed flag or counter");
   a_first_expiry: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
      running && count_reg == 32'h00000001 && !wr_load && !wr_clear ##1 !wr_load && !wr_clear
      |=> raw_reg && count_reg == load_reg)
      else $error("expiry did not set flag and reload");
   a_ctrl_frozen: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
      ctrl_reg.timeout_interrupt_enable |=> ctrl_reg.timeout_interrupt_enable && $stable(ctrl_reg.reset_output_enable))
      else $error("control changed after enable");
   a_masked_and: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE18]
      wdt_irq |-> $past(raw_next) && ctrl_reg.timeout_interrupt_enable)
      else $error("interrupt without raw flag and enable");
   a_second_reset: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
      expire && raw_reg && ctrl_reg.reset_output_enable && !wr_clear |=> sys_reset_req)
      else $error("second expiry gave no reset");
   a_no_reset_off: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
      !ctrl_reg.reset_output_enable && !sys_reset_req |=> !sys_reset_req)
      else $error("reset raised while reset disabled");
   a_lock_blocks: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      locked_reg && wr && aph_reg.addr == wdtu_pkg::OFF_LOAD |=> $stable(load_reg))
      else $error("locked load register changed");

   // counter movement and zero-load flag
   a_zero_load_raw: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE16]
      wr_load && hwdata == wdtu_pkg::ZERO_WORD && running |=> raw_reg)
      else $error("zero load did not raise flag");

   a_load_now: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE6]
      wr_load |=> count_reg == $past(hwdata))
      else $error("load write did not reach counter");

   a_enable_preload: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
      timeout_interrupt_enable_rise |=> count_reg == load_reg)
      else $error("enable did not preload counter");

   a_count_down: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
      running && !reload && !wr_load |=> count_reg == $past(count_reg) - 32'h00000001)
      else $error("counter did not step down");

   a_idle_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
      !running && !reload && !wr_load |=> $stable(count_reg))
      else $error("counter moved while disabled");

   a_expiry_reload: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
      expire && !wr_load |=> count_reg == load_reg)
      else $error("expiry did not reload counter");

   // reset request
   a_clear_no_reset: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE5]
      wr_clear && !sys_reset_req |=> !sys_reset_req)
      else $error("reset raised despite clear");

   a_reset_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
      sys_reset_req |=> sys_reset_req)
      else $error("reset request dropped");

   // lock and control
   a_unlock_key: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
      wr && hit(aph_reg.addr, wdtu_pkg::OFF_LOCK) && hwdata == wdtu_pkg::UNLOCK_KEY
      |=> !locked_reg)
      else $error("key did not unlock");

   a_lock_other: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      wr && hit(aph_reg.addr, wdtu_pkg::OFF_LOCK) && hwdata != wdtu_pkg::UNLOCK_KEY
      |=> locked_reg)
      else $error("non-key write did not lock");

   a_lock_stays: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      locked_reg && !wr_lock |=> locked_reg)
      else $error("lock fell without lock write");

   a_mask_locked: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
      locked_reg && wr && hit(aph_reg.addr, wdtu_pkg::OFF_IRQ_MASK) |=> $stable(mask_reg))
      else $error("locked mask register changed");

   a_ctrl_write_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
      wr && hit(aph_reg.addr, wdtu_pkg::OFF_CTRL) && ctrl_reg.timeout_interrupt_enable |=> $stable(ctrl_reg))
      else $error("control write taken after enable");

   // flag and interrupt line
   a_raw_needs_cause: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE19]
      $rose(raw_reg) |-> $past(expire || (zero_load && running)))
      else $error("raw flag rose without cause");

   a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE18]
      raw_reg && ctrl_reg.timeout_interrupt_enable && mask_reg && $stable(mask_reg) |-> wdt_irq)
      else $error("interrupt missing while pending");

   a_irq_low: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
      !raw_reg |-> !wdt_irq)
      else $error("interrupt high without flag");

   // bus slave
   a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("slave not ready or not okay");

   a_hrdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !rd_take |=> $stable(hrdata))
      else $error("read data changed without read");

   a_count_read: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_take && hit(ra, wdtu_pkg::OFF_VALUE) |=> hrdata == $past(count_reg))
      else $error("value read wrong");

   a_raw_read: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE19]
      rd_take && hit(ra, wdtu_pkg::OFF_RAW) |=> hrdata == {31'h0, $past(raw_reg)})
      else $error("raw flag read wrong");

   a_load_read: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_take && hit(ra, wdtu_pkg::OFF_LOAD) |=> hrdata == $past(load_reg))
      else $error("load read wrong");

endmodule

`default_nettype wire

//--- verification/wdtu_sys_model.sv
/* wdtu_sys_model: system reset logic latching the reset request; assumes the hclk domain. */
`timescale 1ns/1ps
`default_nettype none
module wdtu_sys_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // request in, what the system saw out
   input wire logic sys_reset_req,
   output logic reset_seen
);
   // latched so that a short request cannot slip past the bench
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) reset_seen <= 1'b0;
      else if (sys_reset_req) reset_seen <= 1'b1;
   end
endmodule
`default_nettype wire

//--- verification/test_watchdog_timeout_unit.sv
/* test_watchdog_timeout_unit: self-checking bench for wdtu_top over AHB-Lite.
   assumes: zero-wait slave, wdtu_sys_model as the system reset logic. */
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timeout_unit;
   logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic hreadyout, hresp, wdt_irq, sys_reset_req, reset_seen;
   int n, errors = 0, samples_checked = 0, cycles = 0;
   wdtu_top u_wdtu_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wdt_irq(wdt_irq),
      .sys_reset_req(sys_reset_req));
   wdtu_sys_model u_wdtu_sys_model (.hclk(hclk), .hresetn(hresetn),
      .sys_reset_req(sys_reset_req), .reset_seen(reset_seen));
   initial forever #5 hclk = ~hclk;
   task close_out;
      if (cycles >= 3000) errors++;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // the full run needs under two hundred cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 3000) close_out();
   end
   task chk(input logic [31:0] g, e);
      samples_checked++;
      if (g !== e) $display("BAD %0t got %h want %h", $time, g, e);
      if (g !== e) errors++;
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= wdtu_pkg::HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(q, e);
      chk({31'h0, hresp}, 32'h0);
   endtask
   // the count keeps moving during the read, so only a window is exact
   task rng(input logic [31:0] lo, hi);
      xfer(1'b0, wdtu_pkg::OFF_VALUE, 32'h0);
      chk({31'h0, q >= lo && q <= hi}, 32'h1);
   endtask
   task wt(input logic lvl);
      for (n = 0; n < 200 && wdt_irq !== lvl; n++) @(posedge hclk);
      chk({31'h0, wdt_irq}, {31'h0, lvl});
   endtask
   task t_first;
      rd(wdtu_pkg::OFF_LOAD, wdtu_pkg::LOAD_RESET);
      rd(12'h800, 32'h0);
      xfer(1'b1, wdtu_pkg::OFF_LOAD, 32'h14);
      xfer(1'b1, wdtu_pkg::OFF_CTRL, 32'h2);
      xfer(1'b1, wdtu_pkg::OFF_CTRL, 32'h3);
      rng(32'h10, 32'h14);
      wt(1'b1);
      rd(wdtu_pkg::OFF_MASKED, 32'h1);
   endtask
   task t_hold;
      xfer(1'b1, wdtu_pkg::OFF_LOAD, 32'h28);
      rng(32'h24, 32'h28);
      wt(1'b1);
      xfer(1'b1, wdtu_pkg::OFF_CTRL, 32'h0);
      rd(wdtu_pkg::OFF_CTRL, 32'h3);
      xfer(1'b1, wdtu_pkg::OFF_IRQ_MASK, 32'h0);
      wt(1'b0);
      xfer(1'b1, wdtu_pkg::OFF_IRQ_MASK, 32'h1);
      wt(1'b1);
      xfer(1'b1, wdtu_pkg::OFF_CLEAR, 32'h5a5a5a5a);
      wt(1'b0);
   endtask
   task t_lock;
      xfer(1'b1, wdtu_pkg::OFF_LOCK, 32'h0);
      rd(wdtu_pkg::OFF_LOCK, wdtu_pkg::LOCKED_READ);
      xfer(1'b1, wdtu_pkg::OFF_LOAD, 32'h5);
      rd(wdtu_pkg::OFF_LOAD, 32'h28);
      xfer(1'b1, wdtu_pkg::OFF_LOCK, wdtu_pkg::UNLOCK_KEY);
      rd(wdtu_pkg::OFF_LOCK, wdtu_pkg::ZERO_WORD);
      xfer(1'b1, wdtu_pkg::OFF_LOAD, 32'h30);
      rd(wdtu_pkg::OFF_LOAD, 32'h30);
   endtask
   task t_second;
      wt(1'b1);
      for (n = 0; n < 200 && reset_seen !== 1'b1; n++) @(posedge hclk);
      chk({31'h0, n >= 44 && n <= 56}, 32'h1);
   endtask
   // the read right after a zero load sees the flag before any expiry could set it
   task t_zero;
      xfer(1'b1, wdtu_pkg::OFF_CLEAR, 32'h1);
      rd(wdtu_pkg::OFF_RAW, 32'h0);
      xfer(1'b1, wdtu_pkg::OFF_LOAD, 32'h0);
      rd(wdtu_pkg::OFF_RAW, 32'h1);
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_first;
      t_hold;
      t_lock;
      t_second;
      t_zero;
      close_out;
   end
endmodule
`default_nettype wire
